/* design/serial_flash_write_guard.v */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "flash_guard_consts.vh"

// Function
// - accept host clocking in mode 0 and mode 3
// - array splits into 256 sectors of 4K bytes, each erasable alone
// - array splits into 16 blocks of 64K bytes, each erasable alone
// - program a 256-byte page; erase sector, block or whole chip
// - accepted program or erase runs self-timed without the host
// - busy flag in status shows program or erase still running
// - select high and nothing running means standby
// - power-up reset puts the command machine in read mode
// - power-up delay timer blocks data changes after reset
// - execute only commands ending on a byte boundary at deselect
// - data-changing commands need the write enable latch set
// - latch clears at reset and when the listed commands are accepted at deselect
// - three level bits shield part of the array
// - write-protect pin low freezes level bits and lock bit
// - deep sleep ignores all but wake and signature read
// - pause pin suspends the link without deselecting
// - incomplete or malformed commands leave the array untouched
// - reads run on through addresses while the host clocks
// - identification: standard three bytes, two legacy forms
// - pause stops the link but running operations go on
// - deselect during pause resets the link; restart needs pin high
// - while selected, pause starts and ends only while serial clock is low
module serial_flash_write_guard #(
  parameter [7:0] MAKER_ID = 8'h5A,
  parameter [7:0] DEV_TYPE = 8'h31,
  parameter [7:0] DEV_SIZE = 8'h14,
  parameter [7:0] SIG_ID = 8'h13,
  parameter [31:0] PAGE_CYC = `PAGE_WRITE_US * `CLK_MHZ,
  parameter [31:0] SECTOR_CYC = `SECTOR_WIPE_US * `CLK_MHZ,
  parameter [31:0] BLOCK_CYC = `BLOCK_WIPE_US * `CLK_MHZ,
  parameter [31:0] CHIP_CYC = `CHIP_WIPE_US * `CLK_MHZ,
  parameter [31:0] STATUS_CYC = `STATUS_WRITE_US * `CLK_MHZ,
  parameter [31:0] PUW_CYC = `POWER_UP_WRITE_DELAY_US * `CLK_MHZ
)(
  input wire sys_clk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire si_i,
  input wire hold_n_i,
  input wire wp_n_i,
  output wire so_o,
  output wire so_oe_o,
  output wire standby_o,
  output wire deep_sleep_o,
  output wire write_in_progress_flag_o,
  output wire write_enable_latch_o,
  output reg [19:0] mem_addr_o,
  input wire [7:0] mem_rdata_i,
  output reg mem_wr_o,
  output reg [7:0] mem_wdata_o,
  output reg mem_erase_o,
  output reg [1:0] mem_erase_kind_o
);

localparam S_IDLE = 2'd0;
localparam S_PROG = 2'd1;
localparam S_WIPE = 2'd2;
localparam S_WAIT = 2'd3;

// ----------------------------------------
// pin sampling
// ----------------------------------------
wire cs_n_s;
wire sclk_s;
wire si_s;
wire hold_n_s;
wire wp_n_s;

pin_sync #(
  .W(5),
  .RST_LVL(5'b11001)
) u_sync (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .pin_i({cs_n_i, hold_n_i, si_i, sclk_i, wp_n_i}),
  .level_o({cs_n_s, hold_n_s, si_s, sclk_s, wp_n_s})
);

// ----------------------------------------
// state
// ----------------------------------------
reg sclk_q;
reg cs_q;
reg paused;
reg [2:0] bit_cnt;
reg [2:0] nbytes;
reg [6:0] sh;
reg [7:0] opcode;
reg [23:0] addr;
reg [7:0] status_new;
reg [7:0] col;
reg [255:0] pvalid;
reg [7:0] page [0:255];
reg [7:0] tx;
reg so;
reg oe;
reg id_tog;
reg write_enable_latch;
reg [2:0] protect_level_bits;
reg status_lock_bit;
reg deep_sleep;
reg [31:0] puw_cnt;
reg pwr_ok;
reg [1:0] st;
reg [7:0] idx;
reg [31:0] timer;
reg [31:0] op_len;
reg [19:0] op_addr;
reg [1:0] wipe_kind;

wire write_in_progress_flag = (st != S_IDLE);
wire [7:0] in_byte = {sh, si_s};
wire [7:0] status;
// sclk edges are not seen while paused or deselected
wire rise = sclk_s & ~sclk_q & ~cs_n_s & ~paused;
wire fall = ~sclk_s & sclk_q & ~cs_n_s & ~paused;
wire cs_up = cs_n_s & ~cs_q;
wire dp_block = deep_sleep & (opcode != `CMD_WAKE);
wire commit = cs_up & ~paused & (bit_cnt == 3'd0) & (nbytes != 3'd0) & ~dp_block;
wire wr_ok = write_enable_latch & ~write_in_progress_flag & pwr_ok;
wire pg_load = (opcode == `CMD_PAGE_WRITE) & ~dp_block & ~write_in_progress_flag;

assign status[`ST_LOCK_BIT] = status_lock_bit;
assign status[6:5] = 2'b00;
assign status[`ST_LEVEL_MSB:`ST_LEVEL_LSB] = protect_level_bits;
assign status[`ST_LATCH_BIT] = write_enable_latch;
assign status[`ST_BUSY_BIT] = write_in_progress_flag;

assign so_o = so;
assign so_oe_o = oe & ~paused & ~cs_n_s;
assign standby_o = cs_n_s & ~write_in_progress_flag;
assign deep_sleep_o = deep_sleep;
assign write_in_progress_flag_o = write_in_progress_flag;
assign write_enable_latch_o = write_enable_latch;

// ----------------------------------------
// protection lookup
// ----------------------------------------
function prot;
  input [2:0] lvl;
  input [3:0] blk;
  begin
    if (lvl == `LEVEL_RESET) begin
      prot = 1'b0;
    end else if (lvl >= `LEVEL_ALL) begin
      prot = 1'b1;
    end else begin
      prot = ({1'b0, blk} >= (5'd16 - (5'd1 << (lvl - 3'd1))));
    end
  end
endfunction

// ----------------------------------------
// pause and edge tracking
// ----------------------------------------
always @(posedge sys_clk_i) begin
  if (rst_i) begin
    sclk_q <= 1'b0;
    cs_q <= 1'b1;
    paused <= 1'b0;
  end else begin
    sclk_q <= sclk_s;
    cs_q <= cs_n_s;
    if (cs_n_s) begin
      paused <= paused & ~hold_n_s;
    end else if (~sclk_s) begin
      paused <= ~hold_n_s;
    end
  end
end

// ----------------------------------------
// shifter, samples on rise, drives on fall
// ----------------------------------------
reg tx_go;
reg [7:0] next_tx;

always @* begin
  tx_go = 1'b0;
  next_tx = tx;
  if (~dp_block) begin
    case (opcode)
      `CMD_STATUS_RD: begin
        tx_go = (nbytes != 3'd0);
        next_tx = status;
      end
      `CMD_STD_ID: begin
        tx_go = (nbytes != 3'd0);
        if (nbytes == 3'd1) begin
          next_tx = MAKER_ID;
        end else if (nbytes == 3'd2) begin
          next_tx = DEV_TYPE;
        end else begin
          next_tx = DEV_SIZE;
        end
      end
      `CMD_READ: begin
        tx_go = (nbytes >= 3'd4) & ~write_in_progress_flag;
        next_tx = mem_rdata_i;
      end
      `CMD_FAST_READ: begin
        tx_go = (nbytes >= 3'd5) & ~write_in_progress_flag;
        next_tx = mem_rdata_i;
      end
      `CMD_WAKE: begin
        tx_go = (nbytes >= 3'd4);
        next_tx = SIG_ID;
      end
      `CMD_MAKER_DEV_ID: begin
        tx_go = (nbytes >= 3'd4);
        next_tx = (addr[0] ^ id_tog) ? SIG_ID : MAKER_ID;
      end
      default: begin
        tx_go = 1'b0;
      end
    endcase
  end
end

always @(posedge sys_clk_i) begin
  if (rst_i) begin
    bit_cnt <= 3'd0;
    nbytes <= 3'd0;
    sh <= 7'h00;
    opcode <= 8'h00;
    addr <= 24'h00_0000;
    status_new <= 8'h00;
    col <= 8'h00;
    pvalid <= 256'h0;
    tx <= 8'h00;
    so <= 1'b0;
    oe <= 1'b0;
    id_tog <= 1'b0;
  end else if (cs_n_s) begin
    bit_cnt <= 3'd0;
    nbytes <= 3'd0;
    oe <= 1'b0;
    id_tog <= 1'b0;
  end else if (rise) begin
    sh <= in_byte[6:0];
    bit_cnt <= bit_cnt + 3'd1;
    if (bit_cnt == 3'd7) begin
      if (nbytes != 3'd7) begin
        nbytes <= nbytes + 3'd1;
      end
      if (nbytes == 3'd0) begin
        opcode <= in_byte;
      end else if (nbytes < 3'd4) begin
        addr <= {addr[15:0], in_byte};
      end
      if (nbytes == 3'd1) begin
        status_new <= in_byte;
      end
      if (pg_load && nbytes == 3'd3) begin
        col <= in_byte;
        pvalid <= 256'h0;
      end
      // data past 256 bytes wraps in the page, last byte wins
      if (pg_load && nbytes >= 3'd4) begin
        page[col] <= in_byte;
        pvalid[col] <= 1'b1;
        col <= col + 8'd1;
      end
    end
  end else if (fall) begin
    if (bit_cnt == 3'd0 && tx_go) begin
      tx <= next_tx;
      so <= next_tx[7];
      oe <= 1'b1;
      id_tog <= ~id_tog;
      if (opcode == `CMD_READ || opcode == `CMD_FAST_READ) begin
        addr <= addr + 24'd1;
      end
    end else begin
      so <= tx[~bit_cnt];
    end
  end
end

// ----------------------------------------
// command commit at deselect
// ----------------------------------------
reg go;
reg [1:0] go_st;
reg [31:0] go_len;
reg [1:0] go_kind;
reg [19:0] go_addr;
reg next_latch;
reg [2:0] next_level;
reg next_lock;
reg next_deep;

always @* begin
  go = 1'b0;
  go_st = S_WAIT;
  go_len = STATUS_CYC;
  go_kind = `WIPE_SECTOR;
  go_addr = addr[19:0];
  next_latch = write_enable_latch;
  next_level = protect_level_bits;
  next_lock = status_lock_bit;
  next_deep = deep_sleep;
  if (commit) begin
    case (opcode)
      `CMD_WR_ENABLE: begin
        if (nbytes == 3'd1 && ~write_in_progress_flag) begin
          next_latch = 1'b1;
        end
      end
      `CMD_WR_DISABLE: begin
        if (nbytes == 3'd1 && ~write_in_progress_flag) begin
          next_latch = 1'b0;
        end
      end
      `CMD_STATUS_WR: begin
        if (nbytes == 3'd2 && wr_ok) begin
          go = 1'b1;
          next_latch = 1'b0;
          if (wp_n_s) begin
            next_level = status_new[`ST_LEVEL_MSB:`ST_LEVEL_LSB];
            next_lock = status_new[`ST_LOCK_BIT];
          end
        end
      end
      `CMD_PAGE_WRITE: begin
        if (nbytes >= 3'd5 && wr_ok && !prot(protect_level_bits, addr[19:16])) begin
          go = 1'b1;
          go_st = S_PROG;
          go_len = PAGE_CYC;
          go_addr = {addr[19:8], 8'h00};
          next_latch = 1'b0;
        end
      end
      `CMD_SECTOR_WIPE: begin
        if (nbytes == 3'd4 && wr_ok && !prot(protect_level_bits, addr[19:16])) begin
          go = 1'b1;
          go_st = S_WIPE;
          go_len = SECTOR_CYC;
          go_addr = {addr[19:12], 12'h000};
          next_latch = 1'b0;
        end
      end
      `CMD_BLOCK_WIPE_A, `CMD_BLOCK_WIPE_B: begin
        if (nbytes == 3'd4 && wr_ok && !prot(protect_level_bits, addr[19:16])) begin
          go = 1'b1;
          go_st = S_WIPE;
          go_len = BLOCK_CYC;
          go_kind = `WIPE_BLOCK;
          go_addr = {addr[19:16], 16'h0000};
          next_latch = 1'b0;
        end
      end
      `CMD_CHIP_WIPE_A, `CMD_CHIP_WIPE_B: begin
        // any shielded block refuses the whole chip erase
        if (nbytes == 3'd1 && wr_ok && protect_level_bits == `LEVEL_RESET) begin
          go = 1'b1;
          go_st = S_WIPE;
          go_len = CHIP_CYC;
          go_kind = `WIPE_CHIP;
          go_addr = 20'h0_0000;
          next_latch = 1'b0;
        end
      end
      `CMD_DEEP_SLEEP: begin
        if (nbytes == 3'd1 && ~write_in_progress_flag) begin
          next_deep = 1'b1;
        end
      end
      `CMD_WAKE: begin
        next_deep = 1'b0;
      end
      default: begin
        go = 1'b0;
      end
    endcase
  end
end

always @(posedge sys_clk_i) begin
  if (rst_i) begin
    write_enable_latch <= 1'b0;
    protect_level_bits <= `LEVEL_RESET;
    status_lock_bit <= 1'b0;
    deep_sleep <= 1'b0;
    puw_cnt <= 32'd0;
    pwr_ok <= 1'b0;
  end else begin
    write_enable_latch <= next_latch;
    protect_level_bits <= next_level;
    status_lock_bit <= next_lock;
    deep_sleep <= next_deep;
    if (~pwr_ok) begin
      puw_cnt <= puw_cnt + 32'd1;
      pwr_ok <= (puw_cnt >= PUW_CYC - 32'd1);
    end
  end
end

// ----------------------------------------
// self-timed array engine
// ----------------------------------------
// engine runs on regardless of pause or deselect
always @(posedge sys_clk_i) begin
  if (rst_i) begin
    st <= S_IDLE;
    idx <= 8'h00;
    timer <= 32'd0;
    op_len <= 32'd0;
    op_addr <= 20'h0_0000;
    wipe_kind <= `WIPE_SECTOR;
  end else begin
    case (st)
      S_IDLE: begin
        if (go) begin
          st <= go_st;
          op_len <= go_len;
          op_addr <= go_addr;
          wipe_kind <= go_kind;
          idx <= 8'h00;
          timer <= 32'd0;
        end
      end
      S_PROG: begin
        idx <= idx + 8'd1;
        if (idx == 8'hFF) begin
          st <= S_WAIT;
        end
      end
      S_WIPE: begin
        st <= S_WAIT;
      end
      default: begin
        timer <= timer + 32'd1;
        if (timer >= op_len - 32'd1) begin
          st <= S_IDLE;
        end
      end
    endcase
  end
end

always @(posedge sys_clk_i) begin
  if (rst_i) begin
    mem_addr_o <= 20'h0_0000;
    mem_wr_o <= 1'b0;
    mem_wdata_o <= 8'h00;
    mem_erase_o <= 1'b0;
    mem_erase_kind_o <= `WIPE_SECTOR;
  end else begin
    mem_wr_o <= (st == S_PROG) & pvalid[idx];
    mem_wdata_o <= page[idx];
    mem_erase_o <= (st == S_WIPE);
    mem_erase_kind_o <= wipe_kind;
    if (st == S_PROG) begin
      mem_addr_o <= {op_addr[19:8], idx};
    end else if (st == S_WIPE) begin
      mem_addr_o <= op_addr;
    end else begin
      mem_addr_o <= addr[19:0];
    end
  end
end

endmodule // serial_flash_write_guard

/* design/flash_guard_consts.vh */
`ifndef FLASH_GUARD_CONSTS_VH
`define FLASH_GUARD_CONSTS_VH

// ----------------------------------------
// command opcodes
// ----------------------------------------
`define CMD_WR_ENABLE 8'h06
`define CMD_WR_DISABLE 8'h04
`define CMD_STD_ID 8'h9F
`define CMD_STATUS_RD 8'h05
`define CMD_STATUS_WR 8'h01
`define CMD_READ 8'h03
`define CMD_FAST_READ 8'h0B
`define CMD_SECTOR_WIPE 8'h20
`define CMD_BLOCK_WIPE_A 8'h52
`define CMD_BLOCK_WIPE_B 8'hD8
`define CMD_CHIP_WIPE_A 8'h60
`define CMD_CHIP_WIPE_B 8'hC7
`define CMD_PAGE_WRITE 8'h02
`define CMD_DEEP_SLEEP 8'hB9
`define CMD_WAKE 8'hAB
`define CMD_MAKER_DEV_ID 8'h90

// ----------------------------------------
// status byte layout and reset values
// ----------------------------------------
`define ST_BUSY_BIT 0
`define ST_LATCH_BIT 1
`define ST_LEVEL_LSB 2
`define ST_LEVEL_MSB 4
`define ST_LOCK_BIT 7
`define LEVEL_RESET 3'h0
`define LEVEL_ALL 3'h5

// ----------------------------------------
// array erase kinds
// ----------------------------------------
`define WIPE_SECTOR 2'h0
`define WIPE_BLOCK 2'h1
`define WIPE_CHIP 2'h2

// ----------------------------------------
// timing, microseconds, clock in MHz
// ----------------------------------------
`define CLK_MHZ 250
`define PAGE_WRITE_US 5000
`define SECTOR_WIPE_US 120000
`define BLOCK_WIPE_US 2000000
`define CHIP_WIPE_US 8000000
`define STATUS_WRITE_US 100
`define POWER_UP_WRITE_DELAY_US 10

`endif

/* design/pin_sync.v */
`timescale 1ns/10ps

// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
// a change is taken once stages two and three agree
module pin_sync #(
  parameter W = 5,
  parameter [W-1:0] RST_LVL = {W{1'b1}}
)(
  input wire sys_clk_i,
  input wire rst_i,
  input wire [W-1:0] pin_i,
  output wire [W-1:0] level_o
);

genvar g;
generate
  for (g = 0; g < W; g = g + 1) begin : g_bit
    reg s1;
    reg s2;
    reg s3;
    reg lvl;
    always @(posedge sys_clk_i) begin
      if (rst_i) begin
        s1 <= RST_LVL[g];
        s2 <= RST_LVL[g];
        s3 <= RST_LVL[g];
        lvl <= RST_LVL[g];
      end else begin
        s1 <= pin_i[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          lvl <= s3;
        end
      end
    end
    assign level_o[g] = lvl;
  end
endgenerate

endmodule // pin_sync

/* testbench/flash_guard_asserts.sv */
`timescale 1ns/10ps
// ----------------------------------------
// port checker
// ----------------------------------------
module flash_guard_asserts (
  input wire sys_clk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire so_oe_o,
  input wire standby_o,
  input wire deep_sleep_o,
  input wire write_in_progress_flag_o,
  input wire write_enable_latch_o,
  input wire mem_wr_o,
  input wire mem_erase_o,
  input wire [1:0] mem_erase_kind_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  chk_standby_not_busy: assert property (standby_o |-> !write_in_progress_flag_o)
    else $error("standby while busy");
  chk_write_in_busy: assert property (mem_wr_o |-> write_in_progress_flag_o)
    else $error("array write outside busy");
  chk_erase_in_busy: assert property (mem_erase_o |-> write_in_progress_flag_o)
    else $error("array erase outside busy");
  chk_erase_kind_valid: assert property (mem_erase_o |-> mem_erase_kind_o != 2'h3)
    else $error("bad erase kind");
  chk_start_at_deselect: assert property ($rose(write_in_progress_flag_o) |-> $past(cs_n_i, 3))
    else $error("operation began while selected");
  chk_latch_clear_start: assert property ($rose(write_in_progress_flag_o) |-> ##[0:2] !write_enable_latch_o)
    else $error("latch kept after start");
  chk_latch_set_idle: assert property ($rose(write_enable_latch_o) |-> !write_in_progress_flag_o)
    else $error("latch set while busy");
  chk_deep_idle_only: assert property (deep_sleep_o |-> !write_in_progress_flag_o)
    else $error("deep sleep while busy");
  chk_deselect_quiet: assert property (cs_n_i [*8] |-> !so_oe_o)
    else $error("output driven while deselected");
endmodule // flash_guard_asserts

bind serial_flash_write_guard flash_guard_asserts i_chk (.sys_clk_i, .rst_i, .cs_n_i, .so_oe_o,
  .standby_o, .deep_sleep_o, .write_in_progress_flag_o, .write_enable_latch_o, .mem_wr_o,
  .mem_erase_o, .mem_erase_kind_o);

/* testbench/spi_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// spi host, mode 0 or 3, link clock 80 ns
// ----------------------------------------
module spi_host_model (
  input wire sys_clk_i,
  input wire so_i,
  input wire so_oe_i,
  output reg cs_n_o,
  output reg sclk_o,
  output reg si_o
);
  reg so_last = 1'b0;
  reg idle_hi = 1'b0;
  wire so_w;
  // a released line shows the inverse of its last value, never a stale copy
  assign so_w = so_oe_i ? so_i : ~so_last;
  always @(posedge sys_clk_i) begin
    if (so_oe_i) begin
      so_last <= so_i;
    end
  end
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  task open(input bit m3);
    begin
      @(posedge sys_clk_i);
      idle_hi = m3;
      sclk_o <= m3;
      repeat (10) @(posedge sys_clk_i);
      cs_n_o <= 1'b0;
    end
  endtask
  // nb below 8 sends a broken byte
  task xfer(input [7:0] b, input int nb, output [7:0] r);
    begin
      r = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
        repeat (10) @(posedge sys_clk_i);
        sclk_o <= 1'b0;
        si_o <= b[i];
        repeat (10) @(posedge sys_clk_i);
        sclk_o <= 1'b1;
        r[i] = so_w;
      end
    end
  endtask
  task close();
    begin
      repeat (10) @(posedge sys_clk_i);
      sclk_o <= idle_hi;
      repeat (2) @(posedge sys_clk_i);
      cs_n_o <= 1'b1;
      repeat (40) @(posedge sys_clk_i);
    end
  endtask
endmodule // spi_host_model

/* testbench/serial_flash_write_guard_bench.sv */
`timescale 1ns/10ps
module serial_flash_write_guard_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg hold_n = 1'b1;
  reg wp_n = 1'b1;
  reg [7:0] mem_rdata = 8'h00;
  wire cs_n, sclk, si, so, so_oe, standby, deep, busy, latch, mem_wr, mem_erase;
  wire [19:0] mem_addr;
  wire [7:0] mem_wdata;
  wire [1:0] er_kind;
  int miscompares = 0;
  int checked = 0;
  int wr_cnt = 0;
  int er_cnt = 0;
  reg [21:0] er_last = 22'h00_0000;
  reg [7:0] wr_first = 8'h00;
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  always #2 clk = ~clk;
  serial_flash_write_guard #(.PUW_CYC(20), .PAGE_CYC(300), .SECTOR_CYC(50), .BLOCK_CYC(60),
    .CHIP_CYC(70), .STATUS_CYC(30)) i_dut (.sys_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n),
    .sclk_i(sclk), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe),
    .standby_o(standby), .deep_sleep_o(deep), .write_in_progress_flag_o(busy),
    .write_enable_latch_o(latch), .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata),
    .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .mem_erase_o(mem_erase),
    .mem_erase_kind_o(er_kind));
  spi_host_model i_host (.sys_clk_i(clk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
    .sclk_o(sclk), .si_o(si));
  // ----------------------------------------
  // array stand-in: data is a pattern of the address
  // ----------------------------------------
  always @(posedge clk) begin
    mem_rdata <= mem_addr[7:0] ^ 8'h3c;
    if (mem_wr) wr_cnt <= wr_cnt + 1;
    if (mem_wr && mem_addr == 20'h0_1000) wr_first <= mem_wdata;
    if (mem_erase) er_cnt <= er_cnt + 1;
    if (mem_erase) er_last <= {er_kind, mem_addr};
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task frame(input bit m3, input int nrd, input int xb);
    logic [7:0] r;
    begin
      rx.delete();
      i_host.open(m3);
      foreach (tx[i]) i_host.xfer(tx[i], 8, r);
      for (int i = 0; i < nrd; i++) begin
        i_host.xfer(8'h00, 8, r);
        rx.push_back(r);
      end
      if (xb > 0) i_host.xfer(8'h00, xb, r);
      i_host.close();
      tx.delete();
    end
  endtask
  task stat(input [7:0] exp);
    tx = {8'h05};
    frame(0, 1, 0);
    cmp(rx[0], exp);
  endtask
  task write_enable_cmd();
    tx = {8'h06};
    frame(0, 0, 0);
  endtask
  task wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    cmp(busy, 1'b0);
  endtask
  task close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    // the sync flops load their reset level on the first edge of reset
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    cmp(standby, 1'b1);
    stat(8'h00);
    tx = {8'h9f};
    frame(0, 3, 0);
    cmp({rx[0], rx[1], rx[2]}, 24'h5a_3114);
    $display("test 1 done");
    tx = {8'h03, 8'h01, 8'h23, 8'hfe};
    frame(1, 3, 0);
    for (int i = 0; i < 3; i++) cmp(rx[i], ((8'hfe + i) & 8'hff) ^ 8'h3c);
    $display("test 2 done");
    tx = {8'h06};
    frame(1, 0, 0);
    cmp(latch, 1'b1);
    stat(8'h02);
    tx = {8'h04};
    frame(0, 0, 0);
    cmp(latch, 1'b0);
    tx = {8'h02, 8'h00, 8'h10, 8'h00, 8'haa, 8'h55};
    frame(0, 0, 0);
    cmp({busy, 8'h00} | wr_cnt, 0);
    $display("test 3 done");
    write_enable_cmd();
    tx = {8'h02, 8'h00, 8'h10, 8'h00, 8'haa, 8'h55};
    frame(0, 0, 0);
    cmp({busy, latch}, 2'h2);
    write_enable_cmd();
    cmp(latch, 1'b0);
    wait_idle();
    cmp(wr_first, 8'haa);
    $display("test 4 done");
    write_enable_cmd();
    tx = {8'h20, 8'h00, 8'h30, 8'h00};
    frame(0, 0, 4);
    cmp({er_cnt, latch}, 33'h0_0000_0001);
    for (int k = 0; k < 3; k++) begin
      write_enable_cmd();
      if (k == 0) tx = {8'h20, 8'h00, 8'h30, 8'h00};
      if (k == 1) tx = {8'hd8, 8'h05, 8'h00, 8'h00};
      if (k == 2) tx = {8'h60};
      frame(0, 0, 0);
      wait_idle();
      cmp(latch, 1'b0);
      cmp(er_last, {k[1:0], (k == 0) ? 20'h0_3000 : (k == 1) ? 20'h5_0000 : 20'h0_0000});
    end
    cmp(er_cnt, 3);
    $display("test 5 done");
    write_enable_cmd();
    tx = {8'h01, 8'h04};
    frame(0, 0, 0);
    wait_idle();
    stat(8'h04);
    write_enable_cmd();
    tx = {8'hd8, 8'h0f, 8'h00, 8'h00};
    frame(0, 0, 0);
    cmp(er_cnt, 3);
    wp_n <= 1'b0;
    tx = {8'h01, 8'h00};
    frame(0, 0, 0);
    wait_idle();
    stat(8'h04);
    wp_n <= 1'b1;
    write_enable_cmd();
    tx = {8'h01, 8'h00};
    frame(0, 0, 0);
    wait_idle();
    stat(8'h00);
    $display("test 6 done");
    tx = {8'hb9};
    frame(0, 0, 0);
    cmp(deep, 1'b1);
    write_enable_cmd();
    cmp(latch, 1'b0);
    tx = {8'hab};
    frame(0, 0, 0);
    cmp(deep, 1'b0);
    $display("test 7 done");
    // select rising while paused must drop the command
    hold_n <= 1'b0;
    write_enable_cmd();
    hold_n <= 1'b1;
    cmp(latch, 1'b0);
    write_enable_cmd();
    cmp(latch, 1'b1);
    $display("test 8 done");
    close_out();
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares = miscompares + 1;
    close_out();
  end
endmodule // serial_flash_write_guard_bench
